/* File: bench/txtrm_host.sv */
// Host side model: an APB master that software would drive.
// Assumes one clock shared with the register slice.
`timescale 1ns/100ps
module txtrm_host
   import txtrm_pkg::*;
(
   // Clock
   input wire logic mclk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   // Request held until pready is seen; byte address is four times the index
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic er);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : txtrm_host

/* File: bench/txtrm_regs_asserts.sv */
// Port checker for the trim register slice.
// Assumes it is bound to txtrm_regs.
`timescale 1ns/100ps
module txtrm_regs_asserts
   import txtrm_pkg::*;
(
   // Clock, reset and bus
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Block side
   input wire logic set_default,
   input wire logic cal_valid,
   input wire txtrm_tx_cfg_type tx_cfg,
   input wire logic [3:0] tuning_switch_pins_a,
   input wire logic [3:0] tuning_switch_pins_b,
   input wire logic irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   wire wr = psel && penable && pwrite;
   property p_pins; tuning_switch_pins_a == tuning_switch_pins_b; endproperty
   a_pins: assert property (p_pins) else $error("pin groups differ");
   property p_par; tx_cfg.parity_on == (tx_cfg.split_bits == 3'h0); endproperty
   a_par: assert property (p_par) else $error("parity with split byte");
   property p_def; set_default |=> tx_cfg.full_bytes == 13'h0 && tx_cfg.split_bits == 3'h0; endproperty
   a_def: assert property (p_def) else $error("count not cleared");
   property p_cfg; $changed(tx_cfg) |-> $past(wr) || $past(set_default); endproperty
   a_cfg: assert property (p_cfg) else $error("count moved alone");
   property p_trim; $changed(tuning_switch_pins_a) |-> $past(wr) || $past(cal_valid) || $past(set_default);
   endproperty
   a_trim: assert property (p_trim) else $error("trim moved alone");
   property p_hi; psel && penable |-> prdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_err; psel && penable && paddr[31:2] == 30'h30 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_irq; $fell(irq) |-> $past(wr); endproperty
   a_irq: assert property (p_irq) else $error("irq dropped alone");
endmodule : txtrm_regs_asserts
bind txtrm_regs txtrm_regs_asserts u_txtrm_regs_asserts (.*);

/* File: bench/txtrm_regs_bench.sv */
// Self-checking bench for the trim register slice.
// Assumes txtrm_host drives APB; the bench drives the result sources.
`timescale 1ns/100ps
module txtrm_regs_bench
   import txtrm_pkg::*;
;
   typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd; logic er;} txtrm_row_type;
   logic mclk, nrst, set_default, anticoll_en, card_idle, wakeup_cmd;
   logic rate_valid, adc_valid, cal_valid, cal_err, psel, penable, pwrite, pready, pslverr, irq;
   logic [3:0] rate_code, cal_trim, tuning_switch_pins_a, tuning_switch_pins_b;
   logic [7:0] adc_data;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic er;
   txtrm_tx_cfg_type tx_cfg;
   int fail_count, samples_checked, cyc;
   // Read-only and unmapped rows show writes are ignored
   txtrm_row_type rows [7] = '{'{8'h1d, 8'hab, 8'hab, 1'b0}, '{8'h1e, 8'hff, 8'hff, 1'b0},
      '{8'h21, 8'hff, 8'hf8, 1'b0}, '{8'h21, 8'hc0, 8'hc0, 1'b0}, '{8'h1f, 8'hff, 8'h00, 1'b0},
      '{8'h20, 8'h55, 8'h00, 1'b0}, '{8'h30, 8'h11, 8'h00, 1'b1}};
   txtrm_regs u_txtrm_regs (.*);
   txtrm_host u_txtrm_host (.*);
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      u_txtrm_host.xfer(1'b0, idx, 8'h00, rd, er);
      chk("rdata", rd, {24'h0, exp});
   endtask : rchk
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      u_txtrm_host.xfer(1'b1, idx, d, rd, er);
   endtask : wr
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Generous ceiling; the sequence needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      {nrst, set_default, anticoll_en, card_idle, wakeup_cmd} = 5'h0;
      {rate_valid, adc_valid, cal_valid, cal_err, rate_code, cal_trim, adc_data} = 20'h0;
      fail_count = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      chk("parity", tx_cfg.parity_on, 1'b1);
      chk("pready", pready, 1'b1);
      rchk(8'h21, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd);
         chk("wslverr", er, rows[i].er);
         u_txtrm_host.xfer(1'b0, rows[i].idx, 8'h00, rd, er);
         chk("rdata", rd, {24'h0, rows[i].rd});
         chk("rslverr", er, rows[i].er);
      end
      chk("count", tx_cfg.full_bytes, {8'hab, 5'h1f});
      chk("split", tx_cfg.split_bits, 3'h7);
      chk("parity", tx_cfg.parity_on, 1'b0);
      chk("pins", {tuning_switch_pins_a, tuning_switch_pins_b}, 8'h88);
      @(posedge mclk);
      {cal_trim, cal_valid, adc_data, adc_valid, rate_code, rate_valid} <= {4'h5, 1'b1, 8'h3c, 1'b1, 4'h9, 1'b1};
      @(posedge mclk);
      {cal_valid, adc_valid, rate_valid} <= 3'h0;
      @(posedge mclk);
      chk("pins", tuning_switch_pins_a, 4'h8);
      wr(8'h21, 8'h00);
      // The write lands on the completing edge; look one edge later
      @(posedge mclk);
      chk("pins", {tuning_switch_pins_a, tuning_switch_pins_b}, 8'h55);
      rchk(8'h23, 8'h50);
      rchk(8'h20, 8'h3c);
      rchk(8'h1f, 8'h90);
      chk("irq", irq, 1'b0);
      wr(8'h42, 8'h01);
      {anticoll_en, card_idle, wakeup_cmd} <= 3'h7;
      repeat (2) @(posedge mclk);
      {anticoll_en, card_idle, wakeup_cmd} <= 3'h0;
      repeat (2) @(posedge mclk);
      chk("irq", irq, 1'b1);
      wr(8'h41, 8'h01);
      @(posedge mclk);
      chk("irq", irq, 1'b0);
      set_default <= 1'b1;
      @(posedge mclk);
      set_default <= 1'b0;
      @(posedge mclk);
      rchk(8'h1d, 8'h00);
      rchk(8'h20, 8'h00);
      rchk(8'h1f, 8'h00);
      wr(8'h1e, 8'h0a);
      wr(8'h40, 8'h01);
      rchk(8'h1e, 8'h00);
      chk("parity", tx_cfg.parity_on, 1'b1);
      wrap_up();
   end
endmodule : txtrm_regs_bench

/* File: rtl/txtrm_apb_slave.sv */
// APB slave front end: decodes the strobes into one write and read request.
// Assumes APB3 signalling; answers with no wait states.
`timescale 1ns/100ps
module txtrm_apb_slave
   import txtrm_pkg::*;
(
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   // Decoded request
   output txtrm_apb_req_type req,
   output logic wr_en,
   output logic [7:0] reg_idx,
   output logic idx_ok
);
   wire logic active = psel & penable;
   assign pready = 1'b1;
   assign wr_en = active & pwrite;
   assign reg_idx = paddr[9:2];
   // Misaligned or out-of-window addresses are unmapped
   assign idx_ok = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata, access: active, setup: psel & ~penable};
endmodule : txtrm_apb_slave

/* File: rtl/txtrm_pkg.sv */
// Package for the transmit count and antenna trim register slice.
// Assumes a 32-bit APB master; every register takes one aligned word.
package txtrm_pkg;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [7:0] TXTRM_IDX_NTX_HI = 8'h1d;
   localparam logic [7:0] TXTRM_IDX_NTX_LO = 8'h1e;
   localparam logic [7:0] TXTRM_IDX_RATE = 8'h1f;
   localparam logic [7:0] TXTRM_IDX_ADC = 8'h20;
   localparam logic [7:0] TXTRM_IDX_TUNE = 8'h21;
   localparam logic [7:0] TXTRM_IDX_CALDISP = 8'h23;
   localparam logic [7:0] TXTRM_IDX_CMD = 8'h40;
   localparam logic [7:0] TXTRM_IDX_IRQ_STAT = 8'h41;
   localparam logic [7:0] TXTRM_IDX_IRQ_MASK = 8'h42;
   // Field positions
   localparam int TXTRM_NTX_LSB = 3;
   localparam int TXTRM_SPLIT_MSB = 2;
   localparam int TXTRM_RATE_LSB = 4;
   localparam int TXTRM_TUNE_SEL_BIT = 7;
   localparam int TXTRM_TUNE_VAL_LSB = 3;
   localparam int TXTRM_CAL_VAL_LSB = 4;
   localparam int TXTRM_CAL_ERR_BIT = 3;
   // Reset values
   localparam logic [7:0] TXTRM_RST_8 = 8'h00;
   localparam logic [2:0] TXTRM_SPLIT_NONE = 3'h0;
   localparam logic [12:0] TXTRM_NTX_MAX = 13'h1fff;
   // Interrupt bit positions
   localparam int TXTRM_IRQ_PAR = 0;
   localparam int TXTRM_IRQ_ADC = 1;
   localparam int TXTRM_IRQ_CAL = 2;
   localparam int TXTRM_IRQ_RATE = 3;
   localparam int TXTRM_IRQ_W = 4;
   // Command register bit that loads defaults
   localparam int TXTRM_CMD_DEFAULT_BIT = 0;

   typedef struct packed {
      logic [12:0] full_bytes;
      logic [2:0] split_bits;
      logic parity_on;
   } txtrm_tx_cfg_type;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [31:0] wdata;
      logic access;
      logic setup;
   } txtrm_apb_req_type;
endpackage : txtrm_pkg

/* File: rtl/txtrm_regs.sv */
// Transmit count, bit-rate, converter and antenna trim registers with APB access.
// Assumes the framer, converter, rate detector and calibrator sit outside and
// report through one-cycle pulses with their data.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module txtrm_regs
   import txtrm_pkg::*;
#(
   parameter int TRIM_W = 4
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Set-default command from the command decoder
   input wire logic set_default,
   // Framer side
   input wire logic anticoll_en,
   input wire logic card_idle,
   input wire logic wakeup_cmd,
   output txtrm_tx_cfg_type tx_cfg,
   // Result sources
   input wire logic rate_valid,
   input wire logic [3:0] rate_code,
   input wire logic adc_valid,
   input wire logic [7:0] adc_data,
   input wire logic cal_valid,
   input wire logic [TRIM_W-1:0] cal_trim,
   input wire logic cal_err,
   // Trim switch groups
   output logic [TRIM_W-1:0] tuning_switch_pins_a,
   output logic [TRIM_W-1:0] tuning_switch_pins_b,
   // Interrupt
   output logic irq
);
   // The switch groups and calibration display hold exactly four trim bits
   initial begin
      if (TRIM_W != 4) $error("trim width must be 4");
   end

   txtrm_apb_req_type req;
   logic wr_en;
   logic [7:0] reg_idx;
   logic idx_ok;

   txtrm_apb_slave u_apb (
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .req(req),
      .wr_en(wr_en),
      .reg_idx(reg_idx),
      .idx_ok(idx_ok)
   );

   logic [7:0] ntx_hi_r;
   logic [7:0] ntx_lo_r;
   logic [7:0] rate_r;
   logic [7:0] adc_r;
   logic [7:0] tune_r;
   logic [7:0] caldisp_r;
   logic [TXTRM_IRQ_W-1:0] irq_stat_r;
   logic [TXTRM_IRQ_W-1:0] irq_mask_r;
   logic [7:0] rdata_r;
   logic slverr_r;

   // Index decode
   wire logic hit_hi = idx_ok && reg_idx == TXTRM_IDX_NTX_HI;
   wire logic hit_lo = idx_ok && reg_idx == TXTRM_IDX_NTX_LO;
   wire logic hit_rate = idx_ok && reg_idx == TXTRM_IDX_RATE;
   wire logic hit_adc = idx_ok && reg_idx == TXTRM_IDX_ADC;
   wire logic hit_tune = idx_ok && reg_idx == TXTRM_IDX_TUNE;
   wire logic hit_cal = idx_ok && reg_idx == TXTRM_IDX_CALDISP;
   wire logic hit_cmd = idx_ok && reg_idx == TXTRM_IDX_CMD;
   wire logic hit_stat = idx_ok && reg_idx == TXTRM_IDX_IRQ_STAT;
   wire logic hit_mask = idx_ok && reg_idx == TXTRM_IDX_IRQ_MASK;
   wire logic hit_any = hit_hi | hit_lo | hit_rate | hit_adc | hit_tune | hit_cal | hit_cmd | hit_stat | hit_mask;
   wire logic [7:0] wbyte = req.wdata[7:0];

   // Software default load shares the hardware command's effect
   wire logic sw_default = wr_en && hit_cmd && req.wdata[TXTRM_CMD_DEFAULT_BIT];
   wire logic do_default = set_default | sw_default;

   // Transmit configuration
   wire logic [2:0] split_bits = ntx_lo_r[TXTRM_SPLIT_MSB:0];
   assign tx_cfg.full_bytes = {ntx_hi_r, ntx_lo_r[7:TXTRM_NTX_LSB]};
   assign tx_cfg.split_bits = split_bits;
   // Parity is suppressed whenever a split byte ends the frame
   assign tx_cfg.parity_on = (split_bits == TXTRM_SPLIT_NONE);

   // Interrupt events
   wire logic par_evt = anticoll_en & card_idle & wakeup_cmd & (split_bits != TXTRM_SPLIT_NONE);
   wire logic [TXTRM_IRQ_W-1:0] evt_set = {rate_valid, cal_valid, adc_valid, par_evt};
   wire logic [TXTRM_IRQ_W-1:0] sw_clr = (wr_en && hit_stat) ? wbyte[TXTRM_IRQ_W-1:0] : '0;
   // Set wins over a simultaneous clear so no event is lost
   wire logic [TXTRM_IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~sw_clr) | evt_set;

   // Read mux, unused bits zero
   wire logic [7:0] rd_mux =
      hit_hi ? ntx_hi_r :
      hit_lo ? ntx_lo_r :
      hit_rate ? rate_r :
      hit_adc ? adc_r :
      hit_tune ? tune_r :
      hit_cal ? caldisp_r :
      hit_stat ? {{(8-TXTRM_IRQ_W){1'b0}}, irq_stat_r} :
      hit_mask ? {{(8-TXTRM_IRQ_W){1'b0}}, irq_mask_r} : TXTRM_RST_8;

   // Writable registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ntx_hi_r <= TXTRM_RST_8;
         ntx_lo_r <= TXTRM_RST_8;
         tune_r <= TXTRM_RST_8;
      end else if (do_default) begin
         ntx_hi_r <= TXTRM_RST_8;
         ntx_lo_r <= TXTRM_RST_8;
         tune_r <= TXTRM_RST_8;
      end else if (wr_en) begin
         if (hit_hi) ntx_hi_r <= wbyte;
         if (hit_lo) ntx_lo_r <= wbyte;
         if (hit_tune) tune_r <= {wbyte[7:TXTRM_TUNE_VAL_LSB], 3'h0};
      end
   end

   // Result registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rate_r <= TXTRM_RST_8;
         adc_r <= TXTRM_RST_8;
         caldisp_r <= TXTRM_RST_8;
      end else if (do_default) begin
         rate_r <= TXTRM_RST_8;
         adc_r <= TXTRM_RST_8;
         caldisp_r <= TXTRM_RST_8;
      end else begin
         if (rate_valid) rate_r <= {rate_code, 4'h0};
         if (adc_valid) adc_r <= adc_data;
         if (cal_valid) caldisp_r <= {cal_trim, cal_err, 3'h0};
      end
   end

   // Interrupt registers; the mask survives set-default as it is not part of the map
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_en && hit_mask) irq_mask_r <= wbyte[TXTRM_IRQ_W-1:0];
      end
   end

   // Read data and error registered at setup so they are stable in access
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= TXTRM_RST_8;
         slverr_r <= 1'b0;
      end else if (req.setup) begin
         rdata_r <= req.write ? TXTRM_RST_8 : rd_mux;
         slverr_r <= ~hit_any;
      end
   end

   assign prdata = {24'h000000, rdata_r};
   assign pslverr = slverr_r & req.access;
   assign irq = |(irq_stat_r & irq_mask_r);

   txtrm_trim_mux #(.TRIM_W(TRIM_W)) u_trim (
      .manual_sel(tune_r[TXTRM_TUNE_SEL_BIT]),
      .manual_val(tune_r[6:TXTRM_TUNE_VAL_LSB]),
      .cal_val(caldisp_r[7:TXTRM_CAL_VAL_LSB]),
      .pins_a(tuning_switch_pins_a),
      .pins_b(tuning_switch_pins_b)
   );
endmodule : txtrm_regs

/* File: rtl/txtrm_trim_mux.sv */
// Selects the source that drives the antenna trim switches.
// Assumes both switch groups take the same four-bit pattern.
`timescale 1ns/100ps
module txtrm_trim_mux
   import txtrm_pkg::*;
#(
   parameter int TRIM_W = 4
)
(
   // Selection
   input wire logic manual_sel,
   input wire logic [TRIM_W-1:0] manual_val,
   input wire logic [TRIM_W-1:0] cal_val,
   // Switch groups
   output logic [TRIM_W-1:0] pins_a,
   output logic [TRIM_W-1:0] pins_b
);
   initial begin
      if (TRIM_W != 4) $error("trim width must be 4");
   end
   wire logic [TRIM_W-1:0] chosen = manual_sel ? manual_val : cal_val;
   assign pins_a = chosen;
   assign pins_b = chosen;
endmodule : txtrm_trim_mux
